/* File: common/powerup_boot_params.svh */
// Constants for the power-up and boot sequencer: map bases, sizes, timing.
// Assumes inclusion by bare name from the design file and the testbench.
`ifndef POWERUP_BOOT_PARAMS_SVH
`define POWERUP_BOOT_PARAMS_SVH
// Address map, fixed for ever
`define BOOT_VECTOR_ADDR 32'h0000_0000
`define FLASH_BASE 32'h0000_0000
`define FLASH_SIZE 32'h0004_0000
`define SRAM_BASE 32'h2000_0000
`define SRAM_SIZE 32'h0000_8000
`define CACHE_RAM_BASE 32'h2100_0000
`define CACHE_RAM_SIZE 32'h0000_1000
`define CRYPTO_BASE 32'h400B_0000
`define CRYPTO_SIZE 32'h0000_0100
// Start-up timing
`define CLK_PERIOD_NS 5
`define SETTLE_TIME_NS 1000
`define SETTLE_CYCLES ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Reset values of clocking controls
`define CLK_DIV_RESET 8'h01
`endif

/* File: common/powerup_boot_pkg.sv */
// Types shared by the power-up and boot sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package powerup_boot_pkg;
    // System clock source choices
    typedef enum logic [1:0] {clk_src_system_rc_osc, clk_src_fast_rc, clk_src_pll} clk_src_t;
    // Power scaling settings
    typedef enum logic {power_scale_low, power_scale_high} power_scale_t;
    // Regulator modes
    typedef enum logic [1:0] {reg_normal, reg_low_power, reg_ultra_low_power} reg_mode_t;
    // Power states
    typedef enum logic [2:0] {pstate_run, pstate_sleep, pstate_wait, pstate_retention, pstate_backup} pstate_t;
    // Address decode regions
    typedef enum logic [2:0] {region_flash, region_sram, region_cache_ram, region_crypto, region_none} region_t;
endpackage
`default_nettype wire

/* File: logic/powerup_boot_sequencer.sv */
// Power-up reset hold, strap capture, boot clocking and fixed address decode.
// Assumes a 200 MHz clock from the system RC oscillator domain and that the
// analog supply power-on reset and external reset pin arrive synchronous.
`include "powerup_boot_params.svh"
`default_nettype none

// Summary of operation
// - Hold chip in reset while power settles
// - Boot on system RC, low scaling
// - Loop and PLLs off at start-up
// - All dividers divide by one
// - First fetch from address zero
// - Address decode fixed, never remapped
// - Decode RAM, cache RAM, encryption window
// - Latch regulator strap at power-on release
// - Analog supply reset resets whole chip
// - Backup domain always powered; core off only backup
// - Regulator mode follows power state
// - LCD claims pad clusters by segment count
module powerup_boot_sequencer #(
    parameter int SETTLE_CYCLES = `SETTLE_CYCLES,
    parameter int SEG_W = 6
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic analog_supply_por_in, // High while supply is below threshold
    input wire logic ext_resetn_in, // Reset pin, low holds reset
    input wire logic regulator_type_strap_in, // High switching, low linear
    input wire powerup_boot_pkg::pstate_t pstate_in,
    input wire logic lcd_enable_in,
    input wire logic [SEG_W-1:0] lcd_segments_in,
    input wire logic [31:0] bus_addr_in,
    output logic sys_resetn_out,
    output logic regulator_switching_out,
    output powerup_boot_pkg::clk_src_t clk_src_out,
    output powerup_boot_pkg::power_scale_t power_scale_out,
    output logic freq_locked_loop_en_out,
    output logic pll_en_out,
    output logic [7:0] clk_div_out,
    output logic [31:0] fetch_addr_out,
    output logic fetch_valid_out,
    output powerup_boot_pkg::region_t region_out,
    output logic core_domain_on_out,
    output logic backup_domain_on_out,
    output powerup_boot_pkg::reg_mode_t reg_mode_out,
    output logic [2:0] lcd_cluster_out // Bit set: cluster in LCD mode, pads lost to I/O
);
    import powerup_boot_pkg::*;

    localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);

    // ==========================================================
    // Reset sources
    // ==========================================================
    logic chip_reset; // Any source that must reset the whole chip
    logic [CNT_W-1:0] settle_q; // Cycles of clean supply seen so far
    logic settled;
    logic rel_q; // Release stage, registered so release meets the clock
    logic strap_taken_q; // Strap captured since last power-on release

    // Analog supply reset and the pin both force the chip back into reset
    assign chip_reset = analog_supply_por_in || !ext_resetn_in;
    assign settled = (settle_q == CNT_W'(SETTLE_CYCLES));

    // ==========================================================
    // Settling counter
    // ==========================================================
    // Counts up only while all reset sources are quiet; restarts on any dip
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            settle_q <= '0;
        end
        else if (chip_reset)
        begin
            settle_q <= '0;
        end
        else if (!settled)
        begin
            settle_q <= settle_q + CNT_W'(1);
        end
    end

    // Release is a flop after the count, so it always leaves on an edge
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rel_q <= 1'b0;
        end
        else
        begin
            rel_q <= settled && !chip_reset;
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            sys_resetn_out <= 1'b0;
        end
        else
        begin
            sys_resetn_out <= rel_q && !chip_reset;
        end
    end

    // ==========================================================
    // Regulator strap
    // ==========================================================
    // Taken once on the clock after the power-on reset lets go; later
    // pin activity is ignored, since the regulator cannot change type live
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            strap_taken_q <= 1'b0;
            regulator_switching_out <= 1'b0;
        end
        else if (analog_supply_por_in)
        begin
            strap_taken_q <= 1'b0; // Rearm for the next power-up
        end
        else if (!strap_taken_q)
        begin
            strap_taken_q <= 1'b1;
            regulator_switching_out <= regulator_type_strap_in;
        end
    end

    // ==========================================================
    // Boot clocking
    // ==========================================================
    // Held at boot values while in reset; software reconfigures elsewhere,
    // and is trusted to raise scaling before speeding up
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            clk_src_out <= clk_src_system_rc_osc;
            power_scale_out <= power_scale_low;
            freq_locked_loop_en_out <= 1'b0;
            pll_en_out <= 1'b0;
            clk_div_out <= `CLK_DIV_RESET;
        end
        else if (!sys_resetn_out)
        begin
            clk_src_out <= clk_src_system_rc_osc;
            power_scale_out <= power_scale_low;
            freq_locked_loop_en_out <= 1'b0;
            pll_en_out <= 1'b0;
            clk_div_out <= `CLK_DIV_RESET;
        end
    end

    // ==========================================================
    // Vector fetch
    // ==========================================================
    // One fetch request on the first cycle out of reset
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            fetch_valid_out <= 1'b0;
            fetch_addr_out <= `BOOT_VECTOR_ADDR;
        end
        else
        begin
            fetch_valid_out <= rel_q && !chip_reset && !sys_resetn_out;
            fetch_addr_out <= `BOOT_VECTOR_ADDR;
        end
    end

    // ==========================================================
    // Address decode
    // ==========================================================
    // Pure function of the address: no state, so no remap is possible
    function automatic region_t decode(input logic [31:0] a);
        region_t r;
        r = region_none;
        if (a - `FLASH_BASE < `FLASH_SIZE)
        begin
            r = region_flash;
        end
        else if (a - `SRAM_BASE < `SRAM_SIZE)
        begin
            r = region_sram;
        end
        else if (a - `CACHE_RAM_BASE < `CACHE_RAM_SIZE)
        begin
            r = region_cache_ram;
        end
        else if (a - `CRYPTO_BASE < `CRYPTO_SIZE)
        begin
            r = region_crypto;
        end
        return r;
    endfunction

    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            region_out <= region_none;
        end
        else
        begin
            region_out <= decode(bus_addr_in);
        end
    end

    // ==========================================================
    // Power domains and regulator mode
    // ==========================================================
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            core_domain_on_out <= 1'b1;
            backup_domain_on_out <= 1'b1;
            reg_mode_out <= reg_normal;
        end
        else
        begin
            backup_domain_on_out <= 1'b1;
            core_domain_on_out <= (pstate_in != pstate_backup);
            case (pstate_in)
                pstate_run, pstate_sleep: reg_mode_out <= reg_normal;
                pstate_wait: reg_mode_out <= reg_low_power;
                default: reg_mode_out <= reg_ultra_low_power;
            endcase
        end
    end

    // ==========================================================
    // LCD pad clusters
    // ==========================================================
    // Cluster thresholds follow the large package: A always (bit 0), B above 24 (bit 1),
    // C above 32 (bit 2); the pump sits in cluster A, so it is claimed first
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            lcd_cluster_out <= 3'h0;
        end
        else if (!lcd_enable_in || lcd_segments_in == '0)
        begin
            lcd_cluster_out <= 3'h0;
        end
        else
        begin
            lcd_cluster_out[0] <= 1'b1;
            lcd_cluster_out[1] <= (lcd_segments_in > SEG_W'(24));
            lcd_cluster_out[2] <= (lcd_segments_in > SEG_W'(32));
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    sequence s_release;
        $rose(sys_resetn_out);
    endsequence
    a_reset_holds_on_source: assert property (@(posedge clock_in) disable iff (!resetn_in)
        chip_reset |=> !sys_resetn_out) else $error("reset not asserted after source");
    a_settle_before_release: assert property (@(posedge clock_in) disable iff (!resetn_in)
        s_release |-> $past(settled, 2)) else $error("released before settling");
    a_boot_clock_source: assert property (@(posedge clock_in) disable iff (!resetn_in)
        s_release |-> clk_src_out == clk_src_system_rc_osc && power_scale_out == power_scale_low)
        else $error("wrong boot clock");
    a_loops_off_boot: assert property (@(posedge clock_in) disable iff (!resetn_in)
        s_release |-> !freq_locked_loop_en_out && !pll_en_out) else $error("loops on at boot");
    a_div_by_one: assert property (@(posedge clock_in) disable iff (!resetn_in)
        s_release |-> clk_div_out == `CLK_DIV_RESET) else $error("divider not one");
    a_fetch_at_release: assert property (@(posedge clock_in) disable iff (!resetn_in)
        fetch_valid_out |-> sys_resetn_out && fetch_addr_out == 32'h0000_0000) else $error("fetch not at release");
    a_sram_decode: assert property (@(posedge clock_in) disable iff (!resetn_in)
        bus_addr_in[31:15] == 17'h0_4000 |=> region_out == region_sram) else $error("sram decode");
    a_crypto_decode: assert property (@(posedge clock_in) disable iff (!resetn_in)
        bus_addr_in[31:8] == 24'h40_0B00 |=> region_out == region_crypto) else $error("crypto decode");
    a_backup_power: assert property (@(posedge clock_in) disable iff (!resetn_in)
        pstate_in == pstate_backup |=> !core_domain_on_out && backup_domain_on_out
        && reg_mode_out == reg_ultra_low_power) else $error("backup power");
    a_wait_reg_mode: assert property (@(posedge clock_in) disable iff (!resetn_in)
        pstate_in == pstate_wait |=> reg_mode_out == reg_low_power) else $error("wait reg mode");
    a_strap_hold: assert property (@(posedge clock_in) disable iff (!resetn_in)
        strap_taken_q && $past(strap_taken_q) && !analog_supply_por_in |=> $stable(regulator_switching_out))
        else $error("strap changed");
endmodule
`default_nettype wire

/* File: testbench/supply_supervisor_model.sv */
// Board supply ramp and external reset supervisor facing the sequencer.
// Assumes the bench clock; lines change on its falling edge only.
`default_nettype none
module supply_supervisor_model #(
    parameter int POR_CYCLES = 6, // Cycles spent below the analog threshold
    parameter int PIN_EXTRA = 8 // Extra hold of the pin on a slow ramp
) (
    input wire logic clock_in,
    input wire logic power_cycle_in, // Drop the supply and ramp again
    input wire logic slow_ramp_in, // Ramp too slow for the on-chip detector
    input wire logic strap_level_in, // Fitted strap level
    output logic analog_supply_por_out,
    output logic ext_resetn_out,
    output logic regulator_type_strap_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Ramp timer
    int ramp_cnt = 0; // Cycles since the ramp began; saturates
    always @(negedge clock_in)
    begin
        if (power_cycle_in)
        begin
            ramp_cnt <= 0;
        end
        else if (ramp_cnt < 60)
        begin
            ramp_cnt <= ramp_cnt + 1;
        end
    end
    // Early in the ramp the supply sits below threshold
    assign analog_supply_por_out = (ramp_cnt < POR_CYCLES);
    // Slow ramp: the detector cannot be trusted, so the pin stays low longer
    assign ext_resetn_out = !(slow_ramp_in && (ramp_cnt < POR_CYCLES + PIN_EXTRA));
    // A resistor strap only moves when the board is refitted
    assign regulator_type_strap_out = strap_level_in;
endmodule
`default_nettype wire

/* File: testbench/powerup_boot_sequencer_tb.sv */
// Self-checking bench for the power-up and boot sequencer.
// Assumes the supervisor model and a 200 MHz clock; settle count shortened.
`include "powerup_boot_params.svh"
`default_nettype none
module powerup_boot_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import powerup_boot_pkg::*;
    // ==========================================
    // Stimulus and observed signals
    localparam int SETTLE = 4; // Short settle so runs stay brief
    logic clock_in = 1'b0;
    logic resetn_in = 1'b0;
    logic power_cycle = 1'b0;
    logic slow_ramp = 1'b0;
    logic strap_level = 1'b1;
    logic por, ext_resetn, strap;
    pstate_t pstate = pstate_run;
    logic lcd_enable = 1'b0;
    logic [5:0] lcd_segments = 6'h00;
    logic [31:0] bus_addr = 32'h0000_0000;
    logic sys_resetn, reg_sw, fll_en, pll_en, fetch_valid, core_on, backup_on;
    clk_src_t clk_src;
    power_scale_t scale;
    logic [7:0] clk_div;
    logic [31:0] fetch_addr;
    region_t region;
    reg_mode_t reg_mode;
    logic [2:0] lcd_cluster;
    int error_cnt = 0;
    int num_checks = 0;
    always #2.5 clock_in = ~clock_in;
    supply_supervisor_model supply_supervisor_model_i (.clock_in(clock_in), .power_cycle_in(power_cycle),
        .slow_ramp_in(slow_ramp), .strap_level_in(strap_level), .analog_supply_por_out(por),
        .ext_resetn_out(ext_resetn), .regulator_type_strap_out(strap));
    powerup_boot_sequencer #(.SETTLE_CYCLES(SETTLE), .SEG_W(6)) powerup_boot_sequencer_i (.clock_in(clock_in),
        .resetn_in(resetn_in), .analog_supply_por_in(por), .ext_resetn_in(ext_resetn),
        .regulator_type_strap_in(strap), .pstate_in(pstate), .lcd_enable_in(lcd_enable),
        .lcd_segments_in(lcd_segments), .bus_addr_in(bus_addr), .sys_resetn_out(sys_resetn),
        .regulator_switching_out(reg_sw), .clk_src_out(clk_src), .power_scale_out(scale),
        .freq_locked_loop_en_out(fll_en), .pll_en_out(pll_en), .clk_div_out(clk_div),
        .fetch_addr_out(fetch_addr), .fetch_valid_out(fetch_valid), .region_out(region),
        .core_domain_on_out(core_on), .backup_domain_on_out(backup_on), .reg_mode_out(reg_mode),
        .lcd_cluster_out(lcd_cluster));
    // ==========================================
    // Compare and report
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
        begin
            $display("TEST PASSED");
        end
        else
        begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ==========================================
    // Scenarios
    // Counts quiet cycles until release; the hold must cover the settle time
    task automatic boot_and_check(input logic strap_exp);
        int n, k;
        logic prev_valid;
        n = 0;
        prev_valid = 1'b0;
        for (k = 0; k < 200 && sys_resetn !== 1'b1; k++)
        begin
            prev_valid = fetch_valid;
            @(posedge clock_in);
            n = (por || !ext_resetn) ? 0 : n + 1;
            @(negedge clock_in);
        end
        // Count done, then the release stage, then the output flop: two edges past the count
        check("released", sys_resetn, 1);
        check("hold_cycles", n, SETTLE + 2);
        // The fetch request rises together with the release, never before it
        check("fetch_early", prev_valid, 0);
        check("fetch_pulse", fetch_valid, 1);
        check("fetch_addr", fetch_addr, `BOOT_VECTOR_ADDR);
        @(negedge clock_in);
        check("fetch_once", fetch_valid, 0);
        check("clk_src", clk_src, clk_src_system_rc_osc);
        check("scale", scale, power_scale_low);
        check("fll_en", fll_en, 0);
        check("pll_en", pll_en, 0);
        check("clk_div", clk_div, `CLK_DIV_RESET);
        check("reg_sw", reg_sw, strap_exp);
    endtask
    // Supply dip mid-run resets the chip, decode stays put, then reboots
    task automatic power_cycle_boot(input logic slow, input logic strap_v);
        slow_ramp = slow;
        strap_level = strap_v;
        bus_addr = `SRAM_BASE;
        power_cycle <= 1'b1;
        @(negedge clock_in);
        power_cycle <= 1'b0;
        repeat (3) @(negedge clock_in);
        check("chip_reset", sys_resetn, 0);
        check("boot_decode", region, region_sram);
        boot_and_check(strap_v);
    endtask
    // Strap moves after capture and must be ignored
    task automatic strap_refused();
        strap_level = ~reg_sw;
        repeat (4) @(negedge clock_in);
        check("strap_held", reg_sw, !strap_level);
    endtask
    // Both edges of flash and SRAM, the top edge of cache RAM and crypto, and the gap just above each
    task automatic decode_check();
        logic [31:0] a [10] = '{32'h0000_0000, 32'h0003_FFFF, 32'h0004_0000, 32'h2000_0000, 32'h2000_7FFF,
            32'h2000_8000, 32'h2100_0FFF, 32'h2100_1000, 32'h400B_00FF, 32'h400B_0100};
        region_t e [10] = '{region_flash, region_flash, region_none, region_sram, region_sram,
            region_none, region_cache_ram, region_none, region_crypto, region_none};
        for (int k = 0; k < 10; k++)
        begin
            bus_addr = a[k];
            @(negedge clock_in);
            check("region", region, e[k]);
        end
    endtask
    // Every power state against regulator mode and domains
    task automatic pstate_check();
        reg_mode_t e [5] = '{reg_normal, reg_normal, reg_low_power, reg_ultra_low_power, reg_ultra_low_power};
        for (int k = 0; k < 5; k++)
        begin
            pstate = pstate_t'(k);
            @(negedge clock_in);
            check("reg_mode", reg_mode, e[k]);
            check("core_on", core_on, k != 4);
            check("backup_on", backup_on, 1);
        end
        pstate = pstate_run;
    endtask
    // Segment counts across each cluster threshold
    task automatic lcd_check();
        logic [6:0] s [8] = '{7'h28, 7'h40, 7'h41, 7'h58, 7'h59, 7'h60, 7'h61, 7'h68};
        logic [2:0] e [8] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h3, 3'h3, 3'h7, 3'h7};
        for (int k = 0; k < 8; k++)
        begin
            {lcd_enable, lcd_segments} = s[k];
            @(negedge clock_in);
            check("lcd_cluster", lcd_cluster, e[k]);
        end
    endtask
    // ==========================================
    // Main sequence and watchdog
    initial
    begin
        repeat (12) @(negedge clock_in);
        resetn_in = 1'b1;
        boot_and_check(1'b1);
        strap_refused();
        decode_check();
        pstate_check();
        lcd_check();
        power_cycle_boot(1'b1, 1'b0);
        power_cycle_boot(1'b0, 1'b1);
        complete_run();
    end
    initial
    begin
        #20000;
        error_cnt++;
        complete_run();
    end
endmodule
`default_nettype wire
